// [verilog/cmd_transmit_map.vh]
// Constants for the command-mode direct transmit interpreter
`ifndef CMD_TRANSMIT_MAP_VH
`define CMD_TRANSMIT_MAP_VH
`define INTRO_CHAR 8'h24
`define COLON_CHAR 8'h3A
`define DIGIT_LO 8'h30
`define DIGIT_HI 8'h39
`define UPPER_LO 8'h41
`define UPPER_HI 8'h46
`define LOWER_LO 8'h61
`define LOWER_HI 8'h66
`define LETTER_OFS 4'h9
`define BUF_DEPTH 16
`define LEN_W 4
`endif

// [verilog/command_mode_packet_transmit.v]
// Direct transmit command interpreter for setup mode
`timescale 1ns/100ps
`include "cmd_transmit_map.vh"

// How it works
// - In setup mode a dollar byte starts a direct transmit command.
// - One hex character follows; buffer length is its value plus one.
// - Right after the length character a colon is returned to host.
// - After the final payload byte the radio keys and sends the packet.
// - Once sent, the device returns to setup mode, not data mode.
module command_mode_packet_transmit (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Received serial bytes, setup mode flag
    input wire setupMode,
    input wire [7:0] rxByte,
    input wire rxValid,
    // Reply byte towards the host
    output reg [7:0] ackByte,
    output reg ackValid,
    input wire ackReady,
    // Packet towards the radio
    output reg txKey,
    output reg [7:0] pktByte,
    output reg pktValid,
    input wire pktReady,
    output reg pktLast,
    input wire pktDone,
    // Status
    output reg busy
);

// ----------------------------------------
// State
// ----------------------------------------
localparam IDLE = 5'h01;
localparam LEN = 5'h02;
localparam DATA = 5'h04;
localparam SEND = 5'h08;
localparam WAIT = 5'h10;

reg [4:0] state_q;
reg [4:0] state_d;
reg [3:0] len_q;
reg [3:0] len_d;
reg [3:0] cnt_q;
reg [3:0] cnt_d;
reg [7:0] ackByte_d;
reg ackValid_d;
reg txKey_d;
reg [7:0] pktByte_d;
reg pktValid_d;
reg pktLast_d;
reg busy_d;

// Whole packet kept; the radio may stall between bytes
reg [7:0] buffer [0:`BUF_DEPTH-1];

// ----------------------------------------
// Handshake terms
// ----------------------------------------
wire ackTaken;
wire pktTaken;
wire lastIndex;
wire introSeen;

assign ackTaken = ackValid & ackReady;
assign pktTaken = pktValid & pktReady;
assign lastIndex = (cnt_q == len_q);
// Introducer only counts in setup mode
assign introSeen = setupMode & rxValid & (rxByte == `INTRO_CHAR);

// ----------------------------------------
// Hex decode
// ----------------------------------------
// Lower case accepted as well
reg hexOk;
reg [3:0] hexVal;
always @* begin
    hexOk = 1'b1;
    hexVal = 4'h0;
    if (rxByte >= `DIGIT_LO && rxByte <= `DIGIT_HI) begin
        hexVal = rxByte[3:0];
    end else if ((rxByte >= `UPPER_LO && rxByte <= `UPPER_HI) ||
                 (rxByte >= `LOWER_LO && rxByte <= `LOWER_HI)) begin
        hexVal = rxByte[3:0] + `LETTER_OFS;
    end else begin
        hexOk = 1'b0;
    end
end

// ----------------------------------------
// Payload store
// ----------------------------------------
// No reset; a slot is only read after it is written
always @(posedge mclk) begin
    if (state_q == DATA && rxValid) begin
        buffer[cnt_q] <= rxByte;
    end
end

// ----------------------------------------
// Next state
// ----------------------------------------
always @* begin
    state_d = state_q;
    len_d = len_q;
    cnt_d = cnt_q;
    ackByte_d = ackByte;
    ackValid_d = ackValid;
    txKey_d = txKey;
    pktByte_d = pktByte;
    pktValid_d = pktValid;
    pktLast_d = pktLast;
    busy_d = busy;
    // Clear first, so a fresh colon in the same cycle wins
    if (ackTaken) begin
        ackValid_d = 1'b0;
    end
    case (state_q)
        IDLE: begin
            busy_d = 1'b0;
            if (introSeen) begin
                busy_d = 1'b1;
                state_d = LEN;
            end
        end
        LEN: begin
            if (rxValid) begin
                if (hexOk) begin
                    len_d = hexVal;
                    cnt_d = 4'h0;
                    ackByte_d = `COLON_CHAR;
                    ackValid_d = 1'b1;
                    state_d = DATA;
                end else begin
                    // Bad length: dropped quietly, no reply
                    state_d = IDLE;
                end
            end
        end
        DATA: begin
            // Bytes counted up to the length value, then keyed
            if (rxValid) begin
                if (lastIndex) begin
                    cnt_d = 4'h0;
                    txKey_d = 1'b1;
                    state_d = SEND;
                end else begin
                    cnt_d = cnt_q + 4'h1;
                end
            end
        end
        SEND: begin
            // Byte held until the radio takes it
            if (!pktValid || pktReady) begin
                pktByte_d = buffer[cnt_q];
                pktValid_d = 1'b1;
                pktLast_d = lastIndex;
                if (lastIndex) begin
                    state_d = WAIT;
                end else begin
                    cnt_d = cnt_q + 4'h1;
                end
            end
        end
        WAIT: begin
            if (pktTaken) begin
                pktValid_d = 1'b0;
                pktLast_d = 1'b0;
            end
            // Radio stays keyed until the last byte is out
            if (pktDone && !pktValid) begin
                txKey_d = 1'b0;
                state_d = IDLE;
            end
        end
        default: begin
            state_d = IDLE;
        end
    endcase
end

// ----------------------------------------
// Registers
// ----------------------------------------
// Every output comes straight from one of these
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        state_q <= IDLE;
        len_q <= 4'h0;
        cnt_q <= 4'h0;
        ackByte <= 8'h00;
        ackValid <= 1'b0;
        txKey <= 1'b0;
        pktByte <= 8'h00;
        pktValid <= 1'b0;
        pktLast <= 1'b0;
        busy <= 1'b0;
    end else begin
        state_q <= state_d;
        len_q <= len_d;
        cnt_q <= cnt_d;
        ackByte <= ackByte_d;
        ackValid <= ackValid_d;
        txKey <= txKey_d;
        pktByte <= pktByte_d;
        pktValid <= pktValid_d;
        pktLast <= pktLast_d;
        busy <= busy_d;
    end
end

endmodule // command_mode_packet_transmit

// [dv/tx_props.sv]
// Assertions
`timescale 1ns/100ps
module tx_props(input wire mclk,rst,setupMode,rxValid,busy,txKey,ackValid,
input wire ackReady,pktValid,pktReady,pktLast,pktDone,
input wire [7:0] rxByte,pktByte,ackByte);
default clocking @(posedge mclk);endclocking
default disable iff(rst);
chk_intro_taken:assert property(!busy&&rxValid&&setupMode&&
rxByte==8'h24|=>busy)else $error("intro");
chk_reply_held:assert property(ackValid&&!ackReady|=>ackValid)
else $error("reply");
chk_byte_held:assert property(pktValid&&!pktReady|=>pktValid&&
$stable(pktByte)&&txKey)else $error("byte");
chk_idle_quiet:assert property(!busy|->!txKey&&!pktValid)
else $error("idle");
chk_colon_byte:assert property(ackValid|->ackByte==8'h3A)
else $error("reply byte");
chk_last_out:assert property(pktValid&&pktReady&&pktLast|=>
!pktValid&&txKey)else $error("last");
chk_done_unkey:assert property(pktDone&&!pktValid&&txKey|=>!txKey)
else $error("unkey");
cover property(ackValid&&ackReady);
cover property(pktValid&&pktReady);
cover property($fell(busy));
endmodule // tx_props
bind command_mode_packet_transmit tx_props u_props(.*);

// [dv/radio_model.sv]
// Radio model
`timescale 1ns/100ps
module radio_model(input wire mclk,pktValid,pktLast,
output reg pktReady=0,pktDone=0);
integer s=88;
always @(posedge mclk)pktDone<=pktValid&&pktReady&&pktLast;
always @(negedge mclk)pktReady<=$random(s);
endmodule // radio_model

// [dv/tb.sv]
// Bench
`timescale 1ns/100ps
module tb;
reg mclk=0,rst=1,setupMode=1,rxValid=0,ackReady=0;
reg [7:0] rxByte=8'h00,d;
reg [8:0] aq[$],pq[$];
wire [7:0] ackByte,pktByte;
wire ackValid,txKey,pktValid,pktReady,pktLast,pktDone,busy;
integer seed=88,bad_count=0,checks_done=0,cyc=0,v,i;
always #20 mclk=~mclk;
always @(negedge mclk)ackReady<=$random(seed);
command_mode_packet_transmit u_dut(.*);
radio_model u_radio(.*);
task chk_ack(input [7:0] g,e);
checks_done++;
bad_count+=g!==e;
if(g!==e)$display("[FAIL] %0t reply %h",$time,g);
endtask
task chk_pkt(input [8:0] g,e);
checks_done++;
bad_count+=g!==e;
if(g!==e)$display("[FAIL] %0t packet %h",$time,g);
endtask
task chk_bit(input g,e);
checks_done++;
bad_count+=g!==e;
if(g!==e)$display("[FAIL] %0t flag %b",$time,g);
endtask
task end_of_test;
bad_count+=aq.size()+pq.size()+(cyc>3999);
$display("checks %0d bad %0d",checks_done,bad_count);
if(bad_count==0&&checks_done>0)$display("Testbench passed");
else $display("Testbench failed");
$finish;
endtask
always @(posedge mclk) begin
if(ackValid&&ackReady)chk_ack(ackByte,aq.pop_front());
if(pktValid&&pktReady)chk_pkt({pktLast,pktByte},pq.pop_front());
if(pktValid&&pktReady)chk_bit(txKey,1'b1);
if(++cyc>3999)end_of_test;
end
task cmd(input [7:0] l,input integer n);
for(i=-2;i<n;i++)begin
d=i<-1?8'h24:i<0?l:$random(seed);
if(i>=0)pq.push_back({i==n-1,d});
if(i==0)aq.push_back(9'h03A);
@(negedge mclk){rxValid,rxByte}={1'b1,d};
end
@(negedge mclk)rxValid=0;
while(busy!==0)@(negedge mclk);
endtask
initial begin
repeat(2)@(negedge mclk);
rst=0;
setupMode=0;
@(negedge mclk){rxValid,rxByte}={1'b1,8'h24};
@(negedge mclk)rxValid=0;
@(negedge mclk)chk_bit(busy,1'b0);
setupMode=1;
for(v=0;v<16;v++)cmd(v<10?48+v:55+v,v+1);
cmd(8'h61,11);
cmd(8'h47,0);
end_of_test;
end
endmodule // tb
